/* File: pwdr_pkg.sv */
// Shared offsets, field positions and reset values of the window and high-address registers
package pwdr_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;

    // Register byte offsets
    localparam logic [11:0] OFS_DMA_ONE_HIGH = 12'h094;
    localparam logic [11:0] OFS_DMA_TWO_HIGH = 12'h0B4;
    localparam logic [11:0] OFS_CSR_WIN_MASK = 12'h0F8;
    localparam logic [11:0] OFS_CSR_WIN_OFFSET = 12'h0FC;
    localparam logic [11:0] OFS_SDRAM_WIN_MASK = 12'h100;
    localparam logic [11:0] OFS_CHAN_STATUS = 12'h180;
    localparam logic [11:0] OFS_CSR_BAR_VIEW = 12'h184;
    localparam logic [11:0] OFS_SDRAM_BAR_VIEW = 12'h188;

    // Window field positions
    localparam int WIN_LSB = 18;
    localparam int WIN_MSB = 27;
    localparam int WIN_W = WIN_MSB - WIN_LSB + 1;
    localparam int HI_LSB = 28;
    localparam int HI_MSB = 31;
    localparam int DIS_BIT = 31;

    // Reset values
    localparam logic [31:0] RST_HIGH_ADDR = 32'h0000_0000;
    localparam logic [WIN_W-1:0] RST_WIN_FIELD = 10'h000;
    localparam logic RST_DISABLE = 1'b0;
    localparam logic [31:0] RST_BAR = 32'h0000_0000;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: pwdr_regbus_if.sv */
// Internal register access bundle between the bus slave and the register bank
`timescale 1ns/1ps
interface pwdr_regbus_if;
    import pwdr_pkg::*;
    logic wrEn;
    logic [ADDR_W-1:0] wrAddr;
    logic [DATA_W-1:0] wrData;
    logic [STRB_W-1:0] wrStrb;
    logic wrErr;
    logic rdEn;
    logic [ADDR_W-1:0] rdAddr;
    logic [DATA_W-1:0] rdData;
    logic rdErr;
    modport slave (output wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr, input wrErr, rdData, rdErr);
    modport regs (input wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr, output wrErr, rdData, rdErr);
endinterface

/* File: pwdr_axi_slave.sv */
// AXI4-Lite slave front end, one write and one read in flight
`timescale 1ns/1ps
module pwdr_axi_slave (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [pwdr_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [pwdr_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [pwdr_pkg::STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pwdr_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [pwdr_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    pwdr_regbus_if.slave rb
);
    import pwdr_pkg::*;

    logic awreadyFf, wreadyFf, bvalidFf, arreadyFf, rvalidFf;
    logic [1:0] brespFf, rrespFf;
    logic [ADDR_W-1:0] awAddrFf, arAddrFf;
    logic [DATA_W-1:0] wDataFf, rDataFf;
    logic [STRB_W-1:0] wStrbFf;

    // Commit once both halves are held; ready stays low until the response is taken
    assign rb.wrEn = !awreadyFf && !wreadyFf && !bvalidFf;
    assign rb.wrAddr = awAddrFf;
    assign rb.wrData = wDataFf;
    assign rb.wrStrb = wStrbFf;
    assign rb.rdEn = !arreadyFf && !rvalidFf;
    assign rb.rdAddr = arAddrFf;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            awreadyFf <= 1'b1;
            wreadyFf <= 1'b1;
            bvalidFf <= 1'b0;
            brespFf <= RESP_OKAY;
            awAddrFf <= '0;
            wDataFf <= '0;
            wStrbFf <= '0;
        end else begin
            if (s_axi_awvalid && awreadyFf) begin
                awreadyFf <= 1'b0;
                awAddrFf <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wreadyFf) begin
                wreadyFf <= 1'b0;
                wDataFf <= s_axi_wdata;
                wStrbFf <= s_axi_wstrb;
            end
            if (rb.wrEn) begin
                bvalidFf <= 1'b1;
                brespFf <= rb.wrErr ? RESP_SLVERR : RESP_OKAY;
            end
            if (bvalidFf && s_axi_bready) begin
                bvalidFf <= 1'b0;
                awreadyFf <= 1'b1;
                wreadyFf <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            arreadyFf <= 1'b1;
            rvalidFf <= 1'b0;
            rrespFf <= RESP_OKAY;
            arAddrFf <= '0;
            rDataFf <= '0;
        end else begin
            if (s_axi_arvalid && arreadyFf) begin
                arreadyFf <= 1'b0;
                arAddrFf <= s_axi_araddr;
            end
            if (rb.rdEn) begin
                rvalidFf <= 1'b1;
                rDataFf <= rb.rdData;
                rrespFf <= rb.rdErr ? RESP_SLVERR : RESP_OKAY;
            end
            if (rvalidFf && s_axi_rready) begin
                rvalidFf <= 1'b0;
                arreadyFf <= 1'b1;
            end
        end
    end

    assign s_axi_awready = awreadyFf;
    assign s_axi_wready = wreadyFf;
    assign s_axi_bvalid = bvalidFf;
    assign s_axi_bresp = brespFf;
    assign s_axi_arready = arreadyFf;
    assign s_axi_rvalid = rvalidFf;
    assign s_axi_rdata = rDataFf;
    assign s_axi_rresp = rrespFf;
endmodule

/* File: pwdr_dac_chan.sv */
// One DMA channel's high PCI address register and chain-complete flag
`timescale 1ns/1ps
module pwdr_dac_chan (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic swWrEn,
    input wire logic [31:0] swWrData,
    input wire logic descFetch,
    input wire logic descFirst,
    input wire logic descUpdHigh,
    input wire logic [31:0] descWord4,
    input wire logic chainEnd,
    input wire logic doneClr,
    output logic [31:0] highAddr,
    output logic dualAddrEn,
    output logic chainDone
);
    import pwdr_pkg::*;

    logic [31:0] highAddrFf;
    logic dualAddrFf;
    logic chainDoneFf;
    logic descLoad;
    logic [31:0] nxt_highAddr;

    // First fetched descriptor always loads; later ones only on the third-word bit
    assign descLoad = descFetch && (descFirst || descUpdHigh);
    // No increment path exists: value only loads, holds or clears
    assign nxt_highAddr = chainEnd ? RST_HIGH_ADDR :
                          descLoad ? descWord4 :
                          swWrEn ? swWrData : highAddrFf;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            highAddrFf <= RST_HIGH_ADDR;
            dualAddrFf <= 1'b0;
            chainDoneFf <= 1'b0;
        end else begin
            highAddrFf <= nxt_highAddr;
            dualAddrFf <= (nxt_highAddr != 32'h0000_0000);
            chainDoneFf <= chainEnd || (chainDoneFf && !doneClr);
        end
    end

    assign highAddr = highAddrFf;
    assign dualAddrEn = dualAddrFf;
    assign chainDone = chainDoneFf;
endmodule

/* File: pwdr_regs_top.sv */
// Top level: window masks, CSR offset, high-address registers and AXI4-Lite access
`timescale 1ns/1ps
module pwdr_regs_top #(
    parameter int NUM_CHAN = 2
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [pwdr_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [pwdr_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [pwdr_pkg::STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pwdr_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [pwdr_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_CHAN-1:0] descFetch,
    input wire logic [NUM_CHAN-1:0] descFirst,
    input wire logic [NUM_CHAN-1:0] descUpdHigh,
    input wire logic [NUM_CHAN-1:0][31:0] descWord4,
    input wire logic [NUM_CHAN-1:0] chainEnd,
    output logic [NUM_CHAN-1:0][31:0] chanHighAddr,
    output logic [NUM_CHAN-1:0] chanDualAddr,
    input wire logic cfgCsrBarWr,
    input wire logic cfgSdramBarWr,
    input wire logic [31:0] cfgBarWrData,
    output logic [31:0] csrBarValue,
    output logic [31:0] sdramBarValue,
    input wire logic csrHit,
    input wire logic [31:0] pciAddr,
    output logic [27:0] csrLocalAddr,
    output logic csrLocalValid
);
    import pwdr_pkg::*;

    pwdr_regbus_if rb ();

    pwdr_axi_slave u_axi (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .rb(rb)
    );

    // Byte-lane merge of a write into an old value
    function automatic logic [31:0] mergeStrb(input logic [31:0] oldVal, input logic [31:0] newVal,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = oldVal;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = newVal[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Word address match, low two bits ignored
    function automatic logic hitOfs(input logic [ADDR_W-1:0] addr, input logic [11:0] ofs);
        return addr[ADDR_W-1:2] == ofs[ADDR_W-1:2];
    endfunction

    logic [WIN_W-1:0] csrMaskFf;
    logic [WIN_W-1:0] csrOffsetFf;
    logic [WIN_W-1:0] sdramMaskFf;
    logic sdramDisFf;
    logic [31:0] csrBarFf;
    logic [31:0] sdramBarFf;
    logic [27:0] csrLocalFf;
    logic csrLocalValidFf;
    logic [NUM_CHAN-1:0][31:0] highAddr;
    logic [NUM_CHAN-1:0] dualAddr;
    logic [NUM_CHAN-1:0] chainDone;

    // Write decode
    logic wrHighOne, wrHighTwo, wrCsrMask, wrCsrOffset, wrSdramMask, wrStatus, wrMapped;
    assign wrHighOne = rb.wrEn && hitOfs(rb.wrAddr, OFS_DMA_ONE_HIGH);
    assign wrHighTwo = rb.wrEn && hitOfs(rb.wrAddr, OFS_DMA_TWO_HIGH);
    assign wrCsrMask = rb.wrEn && hitOfs(rb.wrAddr, OFS_CSR_WIN_MASK);
    assign wrCsrOffset = rb.wrEn && hitOfs(rb.wrAddr, OFS_CSR_WIN_OFFSET);
    assign wrSdramMask = rb.wrEn && hitOfs(rb.wrAddr, OFS_SDRAM_WIN_MASK);
    assign wrStatus = rb.wrEn && hitOfs(rb.wrAddr, OFS_CHAN_STATUS);
    // Base address views are read-only from this side
    assign wrMapped = wrHighOne || wrHighTwo || wrCsrMask || wrCsrOffset || wrSdramMask || wrStatus
                      || hitOfs(rb.wrAddr, OFS_CSR_BAR_VIEW) || hitOfs(rb.wrAddr, OFS_SDRAM_BAR_VIEW);
    assign rb.wrErr = !wrMapped;

    // Register images, undefined bits forced to zero
    logic [31:0] csrMaskWord, csrOffsetWord, sdramMaskWord, statusWord;
    assign csrMaskWord = {4'h0, csrMaskFf, 18'h0_0000};
    assign csrOffsetWord = {4'h0, csrOffsetFf, 18'h0_0000};
    assign sdramMaskWord = {sdramDisFf, 3'h0, sdramMaskFf, 18'h0_0000};
    assign statusWord = {{(32-NUM_CHAN){1'b0}}, chainDone};

    logic [31:0] csrMaskMerge, csrOffsetMerge, sdramMaskMerge;
    assign csrMaskMerge = mergeStrb(csrMaskWord, rb.wrData, rb.wrStrb);
    assign csrOffsetMerge = mergeStrb(csrOffsetWord, rb.wrData, rb.wrStrb);
    assign sdramMaskMerge = mergeStrb(sdramMaskWord, rb.wrData, rb.wrStrb);

    // Window registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            csrMaskFf <= RST_WIN_FIELD;
            csrOffsetFf <= RST_WIN_FIELD;
            sdramMaskFf <= RST_WIN_FIELD;
            sdramDisFf <= RST_DISABLE;
        end else begin
            if (wrCsrMask) begin
                csrMaskFf <= csrMaskMerge[WIN_MSB:WIN_LSB];
            end
            if (wrCsrOffset) begin
                csrOffsetFf <= csrOffsetMerge[WIN_MSB:WIN_LSB];
            end
            if (wrSdramMask) begin
                sdramMaskFf <= sdramMaskMerge[WIN_MSB:WIN_LSB];
                sdramDisFf <= sdramMaskMerge[DIS_BIT];
            end
        end
    end

    // Writable-bit maps of the two PCI base registers; low bits hold no storage here
    logic [31:0] csrBarWritable, sdramBarWritable;
    assign csrBarWritable = {4'hF, ~csrMaskFf, 18'h0_0000};
    assign sdramBarWritable = {{4{~sdramDisFf}}, ~sdramMaskFf, 18'h0_0000};

    // Masking applies every cycle, so a bit hidden later also reads zero from the next clock
    logic [31:0] nxt_csrBar, nxt_sdramBar;
    assign nxt_csrBar = (cfgCsrBarWr ? cfgBarWrData : csrBarFf) & csrBarWritable;
    assign nxt_sdramBar = (cfgSdramBarWr ? cfgBarWrData : sdramBarFf) & sdramBarWritable;

    // Inbound control-space translation, mask bit one passes the PCI bit
    logic [WIN_W-1:0] csrWinBits;
    assign csrWinBits = (pciAddr[WIN_MSB:WIN_LSB] & csrMaskFf) | (csrOffsetFf & ~csrMaskFf);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            csrBarFf <= RST_BAR;
            sdramBarFf <= RST_BAR;
            csrLocalFf <= '0;
            csrLocalValidFf <= 1'b0;
        end else begin
            csrBarFf <= nxt_csrBar;
            sdramBarFf <= nxt_sdramBar;
            csrLocalValidFf <= csrHit;
            if (csrHit) begin
                csrLocalFf <= {csrWinBits, pciAddr[WIN_LSB-1:0]};
            end
        end
    end

    // Channel high-address registers
    logic [NUM_CHAN-1:0] chanWr;
    logic [NUM_CHAN-1:0][31:0] chanWrData;
    logic [NUM_CHAN-1:0] doneClr;
    assign chanWr = {wrHighTwo, wrHighOne};

    generate
        for (genvar c = 0; c < NUM_CHAN; c++) begin : gChan
            assign chanWrData[c] = mergeStrb(highAddr[c], rb.wrData, rb.wrStrb);
            // Write one to clear; a chain ending in the same cycle still leaves the flag set
            assign doneClr[c] = wrStatus && rb.wrStrb[0] && rb.wrData[c];
            pwdr_dac_chan u_chan (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .swWrEn(chanWr[c]),
                .swWrData(chanWrData[c]),
                .descFetch(descFetch[c]),
                .descFirst(descFirst[c]),
                .descUpdHigh(descUpdHigh[c]),
                .descWord4(descWord4[c]),
                .chainEnd(chainEnd[c]),
                .doneClr(doneClr[c]),
                .highAddr(highAddr[c]),
                .dualAddrEn(dualAddr[c]),
                .chainDone(chainDone[c])
            );
        end
    endgenerate

    // Read decode
    logic rdHighOne, rdHighTwo, rdCsrMask, rdCsrOffset, rdSdramMask, rdStatus, rdCsrBar, rdSdramBar;
    assign rdHighOne = hitOfs(rb.rdAddr, OFS_DMA_ONE_HIGH);
    assign rdHighTwo = hitOfs(rb.rdAddr, OFS_DMA_TWO_HIGH);
    assign rdCsrMask = hitOfs(rb.rdAddr, OFS_CSR_WIN_MASK);
    assign rdCsrOffset = hitOfs(rb.rdAddr, OFS_CSR_WIN_OFFSET);
    assign rdSdramMask = hitOfs(rb.rdAddr, OFS_SDRAM_WIN_MASK);
    assign rdStatus = hitOfs(rb.rdAddr, OFS_CHAN_STATUS);
    assign rdCsrBar = hitOfs(rb.rdAddr, OFS_CSR_BAR_VIEW);
    assign rdSdramBar = hitOfs(rb.rdAddr, OFS_SDRAM_BAR_VIEW);

    assign rb.rdData = rdHighOne ? highAddr[0] :
                       rdHighTwo ? highAddr[1] :
                       rdCsrMask ? csrMaskWord :
                       rdCsrOffset ? csrOffsetWord :
                       rdSdramMask ? sdramMaskWord :
                       rdStatus ? statusWord :
                       rdCsrBar ? csrBarFf :
                       rdSdramBar ? sdramBarFf : 32'h0000_0000;
    assign rb.rdErr = !(rdHighOne || rdHighTwo || rdCsrMask || rdCsrOffset || rdSdramMask || rdStatus
                        || rdCsrBar || rdSdramBar);

    // Outputs, all from flops
    assign chanHighAddr = highAddr;
    assign chanDualAddr = dualAddr;
    assign csrBarValue = csrBarFf;
    assign sdramBarValue = sdramBarFf;
    assign csrLocalAddr = csrLocalFf;
    assign csrLocalValid = csrLocalValidFf;
endmodule

/* File: pwdr_monitor.sv */
// Port checker for the window and high-address register block
`timescale 1ns/1ps
module pwdr_monitor #(
    parameter int NUM_CHAN = 2
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [NUM_CHAN-1:0] descFetch,
    input wire logic [NUM_CHAN-1:0] descFirst,
    input wire logic [NUM_CHAN-1:0] descUpdHigh,
    input wire logic [NUM_CHAN-1:0][31:0] descWord4,
    input wire logic [NUM_CHAN-1:0] chainEnd,
    input wire logic [NUM_CHAN-1:0][31:0] chanHighAddr,
    input wire logic [NUM_CHAN-1:0] chanDualAddr,
    input wire logic [31:0] csrBarValue,
    input wire logic [31:0] sdramBarValue,
    input wire logic csrHit,
    input wire logic [31:0] pciAddr,
    input wire logic [27:0] csrLocalAddr,
    input wire logic csrLocalValid
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    dual_addr_a: assert property (
        chanDualAddr[0] == (chanHighAddr[0] != 32'h0) && chanDualAddr[1] == (chanHighAddr[1] != 32'h0))
        else $error("dual address flag disagrees with high address");
    clear_one_a: assert property (chainEnd[0] |=> chanHighAddr[0] == 32'h0)
        else $error("high address one not cleared at chain end");
    clear_two_a: assert property (chainEnd[1] |=> chanHighAddr[1] == 32'h0)
        else $error("high address two not cleared at chain end");
    first_load_a: assert property (
        descFetch[0] && descFirst[0] && !chainEnd[0] |=> chanHighAddr[0] == $past(descWord4[0]))
        else $error("first descriptor word four not loaded");
    later_load_a: assert property (
        descFetch[1] && descUpdHigh[1] && !chainEnd[1] |=> chanHighAddr[1] == $past(descWord4[1]))
        else $error("later descriptor word four not loaded");
    keep_value_a: assert property (
        descFetch[0] && !descFirst[0] && !descUpdHigh[0] && !chainEnd[0]
        |=> $rose(s_axi_bvalid) || $stable(chanHighAddr[0]))
        else $error("high address changed on a keep fetch");
    hit_answer_a: assert property (
        csrHit |=> csrLocalValid && csrLocalAddr[17:0] == $past(pciAddr[17:0]))
        else $error("inbound control access not translated");
    bar_low_a: assert property (csrBarValue[17:0] == 18'h0 && sdramBarValue[17:0] == 18'h0)
        else $error("base register low bits not zero");
    write_resp_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");

    cover property (chainEnd[0] ##1 chanHighAddr[0] == 32'h0);
    cover property (descFetch[1] && descUpdHigh[1]);
    cover property (csrLocalValid);
endmodule

bind pwdr_regs_top pwdr_monitor #(.NUM_CHAN(NUM_CHAN)) mon_u (.ref_clk, .rst_n, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .descFetch, .descFirst, .descUpdHigh,
    .descWord4, .chainEnd, .chanHighAddr, .chanDualAddr, .csrBarValue, .sdramBarValue, .csrHit, .pciAddr,
    .csrLocalAddr, .csrLocalValid);

/* File: pwdr_far_model.sv */
// Far side model: descriptor engine, chain ends, config writes, inbound hits
`timescale 1ns/1ps
module pwdr_far_model (
    input wire logic ref_clk,
    output logic [1:0] descFetch,
    output logic [1:0] descFirst,
    output logic [1:0] descUpdHigh,
    output logic [1:0][31:0] descWord4,
    output logic [1:0] chainEnd,
    output logic cfgCsrBarWr,
    output logic cfgSdramBarWr,
    output logic [31:0] cfgBarWrData,
    output logic csrHit,
    output logic [31:0] pciAddr
);
    initial begin
        {descFetch, descFirst, descUpdHigh, chainEnd} = 8'h00;
        {cfgCsrBarWr, cfgSdramBarWr, csrHit} = 3'h0;
        descWord4 = 64'h0;
        cfgBarWrData = 32'h0;
        pciAddr = 32'h0;
    end
    task automatic fetch(input int ch, input logic first, input logic upd, input logic [31:0] w4);
        @(posedge ref_clk);
        descFetch[ch] <= 1'b1;
        descFirst[ch] <= first;
        descUpdHigh[ch] <= upd;
        descWord4[ch] <= w4;
        @(posedge ref_clk);
        descFetch[ch] <= 1'b0;
        descFirst[ch] <= 1'b0;
        descUpdHigh[ch] <= 1'b0;
        descWord4[ch] <= ~w4; // Stale word is not kept
    endtask
    task automatic endChain(input int ch);
        @(posedge ref_clk);
        chainEnd[ch] <= 1'b1;
        @(posedge ref_clk);
        chainEnd[ch] <= 1'b0;
    endtask
    task automatic cfgWrite(input logic [1:0] sel, input logic [31:0] d);
        @(posedge ref_clk);
        cfgCsrBarWr <= sel[0];
        cfgSdramBarWr <= sel[1];
        cfgBarWrData <= d;
        @(posedge ref_clk);
        {cfgCsrBarWr, cfgSdramBarWr} <= 2'h0;
        cfgBarWrData <= ~d;
    endtask
    task automatic hit(input logic [31:0] a);
        @(posedge ref_clk);
        csrHit <= 1'b1;
        pciAddr <= a;
        @(posedge ref_clk);
        csrHit <= 1'b0;
        pciAddr <= ~a;
    endtask
endmodule

/* File: tb_top.sv */
// Self-checking bench for the window and high-address register block
`timescale 1ns/1ps
module tb_top;
    import pwdr_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [STRB_W-1:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [1:0] descFetch, descFirst, descUpdHigh, chainEnd, chanDualAddr;
    logic [1:0][31:0] descWord4, chanHighAddr;
    logic cfgCsrBarWr, cfgSdramBarWr, csrHit, csrLocalValid;
    logic [31:0] cfgBarWrData, csrBarValue, sdramBarValue, pciAddr, m, e;
    logic [27:0] csrLocalAddr;
    logic [11:0] regList [8] = '{OFS_DMA_ONE_HIGH, OFS_DMA_TWO_HIGH, OFS_CSR_WIN_MASK, OFS_CSR_WIN_OFFSET,
        OFS_SDRAM_WIN_MASK, OFS_CHAN_STATUS, OFS_CSR_BAR_VIEW, OFS_SDRAM_BAR_VIEW};
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;

    always #20 ref_clk = ~ref_clk;

    pwdr_regs_top #(.NUM_CHAN(2)) dut_u (.ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .descFetch, .descFirst, .descUpdHigh, .descWord4, .chainEnd, .chanHighAddr,
        .chanDualAddr, .cfgCsrBarWr, .cfgSdramBarWr, .cfgBarWrData, .csrBarValue, .sdramBarValue, .csrHit,
        .pciAddr, .csrLocalAddr, .csrLocalValid);
    pwdr_far_model far_u (.ref_clk, .descFetch, .descFirst, .descUpdHigh, .descWord4, .chainEnd,
        .cfgCsrBarWr, .cfgSdramBarWr, .cfgBarWrData, .csrHit, .pciAddr);

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic axiWrite(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check({30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task automatic axiRead(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, ed);
        check({30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    // Hang guard, generous against roughly 280 cycles of traffic
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            summarize();
        end
    end

    initial begin
        rst_n <= 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
        {s_axi_awaddr, s_axi_araddr} <= 24'h0;
        s_axi_wdata <= 32'h0;
        s_axi_wstrb <= 4'hF;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        foreach (regList[i]) axiRead(regList[i], 32'h0, RESP_OKAY);
        axiWrite(12'h004, 32'hFFFF_FFFF, RESP_SLVERR);
        axiRead(12'h004, 32'h0, RESP_SLVERR);
        axiWrite(OFS_DMA_ONE_HIGH, 32'hA5C3_0001, RESP_OKAY);
        axiWrite(OFS_DMA_TWO_HIGH, 32'h0000_0007, RESP_OKAY);
        axiRead(OFS_DMA_ONE_HIGH, 32'hA5C3_0001, RESP_OKAY);
        check(chanHighAddr[1], 32'h0000_0007);
        check({30'h0, chanDualAddr}, 32'h3);
        far_u.fetch(0, 1'b1, 1'b0, 32'h0);
        @(negedge ref_clk);
        check({chanHighAddr[0][31:1], chanDualAddr[0]}, 32'h0);
        far_u.fetch(0, 1'b0, 1'b0, 32'h1234_5678);
        far_u.fetch(1, 1'b0, 1'b1, 32'hFFFF_FFFF);
        repeat (10) @(posedge ref_clk);
        check(chanHighAddr[0], 32'h0);
        check(chanHighAddr[1], 32'hFFFF_FFFF);
        far_u.endChain(0);
        far_u.endChain(1);
        @(negedge ref_clk);
        check({chanHighAddr[1][31:2], chanDualAddr}, 32'h0);
        axiRead(OFS_CHAN_STATUS, 32'h3, RESP_OKAY);
        axiWrite(OFS_CHAN_STATUS, 32'h1, RESP_OKAY);
        axiRead(OFS_CHAN_STATUS, 32'h2, RESP_OKAY);
        for (int k = 0; k <= 10; k++) begin
            m = ((32'h1 << k) - 32'h1) << 18;
            axiWrite(OFS_CSR_WIN_MASK, m, RESP_OKAY);
            axiWrite(OFS_SDRAM_WIN_MASK, m, RESP_OKAY);
            far_u.cfgWrite(2'h3, 32'hFFFF_FFFF);
            @(negedge ref_clk);
            check(csrBarValue, 32'hFFFC_0000 & ~m);
            check(sdramBarValue, 32'hFFFC_0000 & ~m);
            axiRead(OFS_CSR_WIN_MASK, m, RESP_OKAY);
        end
        axiWrite(OFS_SDRAM_WIN_MASK, 32'h8000_0000, RESP_OKAY);
        far_u.cfgWrite(2'h2, 32'hFFFF_FFFF);
        @(negedge ref_clk);
        check(sdramBarValue, 32'h0FFC_0000);
        axiWrite(OFS_SDRAM_WIN_MASK, 32'hFFFF_FFFF, RESP_OKAY);
        axiRead(OFS_SDRAM_WIN_MASK, 32'h8FFC_0000, RESP_OKAY);
        check(sdramBarValue, 32'h0);
        axiWrite(OFS_CSR_WIN_OFFSET, 32'hF5A5_5555, RESP_OKAY);
        axiRead(OFS_CSR_WIN_OFFSET, 32'h05A4_0000, RESP_OKAY);
        for (int j = 0; j < 2; j++) begin
            m = j ? 32'h003C_0000 : 32'h0;
            axiWrite(OFS_CSR_WIN_MASK, m, RESP_OKAY);
            far_u.hit(32'h3AFF_1234);
            @(negedge ref_clk);
            e = (32'h3AFF_1234 & (m | 32'h3FFFF)) | (32'h05A4_0000 & ~m);
            check({4'h0, csrLocalAddr}, e & 32'h0FFF_FFFF);
            check({31'h0, csrLocalValid}, 32'h1);
        end
        summarize();
    end
endmodule
